// ### bench/scs_osc_model.sv
`default_nettype none
module scs_osc_model
	import scs_pkg::*;
(
	// Stop control, one bit a line
	input wire logic [4:0] i_stop,
	// Oscillator levels
	output scs_osc_t o_osc
);
	timeunit 1ns;
	timeprecision 100ps;
	wire [4:0] lines;
	// Free-running lines of distinct periods; a stopped line freezes
	for (genvar g = 0; g < 5; g++) begin : g_line
		logic level = 1'b0;
		initial begin
			#1;
			forever begin
				#(24 + 4 * g);
				if (!i_stop[g]) begin
					level = ~level;
				end
			end
		end
		// One driver per line
		assign lines[g] = level;
	end
	assign o_osc = scs_osc_t'(lines);
endmodule : scs_osc_model
`default_nettype wire

// ### bench/tb_scs_clock_select.sv
`include "scs_consts.svh"
`default_nettype none
module tb_scs_clock_select
	import scs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	scs_cfg_t i_cfg = 10'h3ff;
	logic i_out_pin_clock_en = 1'b0;
	logic [2:0] i_rc_divider = 3'h1;
	logic i_switch_req = 1'b0;
	logic [2:0] i_new_select = 3'h0;
	logic i_fail_clear = 1'b0;
	logic [4:0] stop = 5'h00;
	scs_osc_t osc;
	logic sys_tick, instr, instr_tick, pin, oe_n, sec_hp, above;
	logic [1:0] range;
	scs_status_t st;
	int mismatches = 0;
	int checked = 0;
	logic [2:0] tsel [12] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1,
		3'h0, 3'h2};
	logic [1:0] tmode [12] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3,
		2'h3, 2'h3};
	int tdiv [8] = '{1, 2, 4, 8, 16, 32, 64, 256};

	// Clock
	always #2 i_clock = ~i_clock;

	scs_clock_select DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_cfg(i_cfg),
		.i_out_pin_clock_en(i_out_pin_clock_en), .i_osc(osc), .i_rc_divider(i_rc_divider),
		.i_switch_req(i_switch_req), .i_new_select(i_new_select), .i_fail_clear(i_fail_clear),
		.o_system_tick(sys_tick), .o_instruction_clock(instr), .o_instruction_tick(instr_tick),
		.o_primary_out_pin(pin), .o_primary_out_oe_n(oe_n), .o_status(st),
		.o_secondary_high_power(sec_hp), .o_ext_range(range), .o_ext_above_8mhz(above));
	scs_osc_model u_osc (.i_stop(stop), .o_osc(osc));

	// Comparisons
	task automatic check_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_sel(input logic [2:0] got, input logic [2:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: field %h expected %h", $time, got, exp);
		end
	endtask : check_sel
	task automatic check_count(input int got, input int exp);
		checked++;
		if (got != exp) begin
			mismatches++;
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : check_count
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// Stimulus helpers, all at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask : cyc
	task automatic do_reset(input logic [2:0] s, input logic [1:0] m, input logic [1:0] sw,
		input logic sec, input logic [1:0] rg);
		@(negedge i_clock);
		i_rstn = 1'b0;
		i_cfg = '{sw, sec, rg, m, s};
		cyc(12);
		i_rstn = 1'b1;
		cyc(3);
	endtask : do_reset
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(negedge i_clock);
			n++;
		end while (sys_tick !== 1'b1 && n < 5000);
	endtask : wait_tick
	task automatic switch_to(input logic [2:0] s);
		i_switch_req = 1'b1;
		i_new_select = s;
		cyc(1);
		i_switch_req = 1'b0;
		cyc(2);
	endtask : switch_to
	function automatic logic [2:0] exp_sel(input logic [2:0] s, input logic [1:0] m);
		return (s[2:1] == 2'h1 && m == 2'h3) ? 3'h0 : s;
	endfunction : exp_sel

	// Watchdog
	initial begin
		#240000;
		mismatches++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end

	// Tests
	initial begin
		logic [1:0] sw;
		logic [1:0] rg;
		logic [2:0] e;
		logic prev;
		logic last;
		int n;
		int np;
		int ni;
		cyc(6);
		check_sel(st.current_select, 3'h7);
		check_bit(st.postscale_on, 1'b1);
		check_bit(st.switch_allowed, 1'b0);
		check_bit(sec_hp, 1'b1);
		check_bit(above, 1'b1);
		check_bit(oe_n, 1'b1);
		cyc(6);
		i_rstn = 1'b1;
		cyc(3);
		$display("test reset done");
		// Power-on decode of every listed mode
		for (int i = 0; i < 12; i++) begin
			sw = 2'(i % 4);
			rg = 2'((i + 1) % 4);
			do_reset(tsel[i], tmode[i], sw, i[0], rg);
			e = exp_sel(tsel[i], tmode[i]);
			check_sel(st.current_select, e);
			check_bit(st.pll_enable, e == 3'h1 || e == 3'h3);
			check_bit(st.postscale_on, e == 3'h1 || e >= 3'h6);
			check_bit(st.switch_allowed, !sw[1]);
			check_bit(st.monitor_active, sw == 2'h0);
			check_bit(sec_hp, i[0]);
			check_sel({1'b0, range}, {1'b0, rg});
			check_bit(above, rg == 2'h3);
		end
		$display("test decode done");
		// Postscaler codes and the half-rate instruction clock
		do_reset(3'h7, 2'h3, 2'h3, 1'b1, 2'h3);
		for (int d = 0; d < 8; d++) begin
			i_rc_divider = 3'(d);
			repeat (3) wait_tick(n);
			wait_tick(n);
			check_count(n, 16 * tdiv[d]);
			prev = instr;
			cyc(1);
			check_bit(instr, ~prev);
		end
		$display("test postscaler done");
		// Instruction clock on the primary output pin
		i_out_pin_clock_en = 1'b1;
		do_reset(3'h2, 2'h0, 2'h3, 1'b1, 2'h3);
		check_bit(oe_n, 1'b0);
		np = 0;
		ni = 0;
		last = pin;
		repeat (240) begin
			cyc(1);
			np += (pin && !last) ? 1 : 0;
			ni += (instr_tick === 1'b1) ? 1 : 0;
			last = pin;
		end
		check_bit(np >= 9 && np <= 11, 1'b1);
		check_bit(ni >= 9 && ni <= 11, 1'b1);
		i_out_pin_clock_en = 1'b0;
		cyc(3);
		check_bit(oe_n, 1'b1);
		check_bit(pin, 1'b0);
		i_out_pin_clock_en = 1'b1;
		do_reset(3'h2, 2'h2, 2'h3, 1'b1, 2'h3);
		check_bit(oe_n, 1'b1);
		$display("test pin done");
		// Runtime switching, refusals and holding of the choice
		do_reset(3'h0, 2'h3, 2'h1, 1'b0, 2'h0);
		switch_to(3'h5);
		check_sel(st.current_select, 3'h5);
		switch_to(3'h1);
		check_sel(st.current_select, 3'h1);
		check_bit(st.pll_enable, 1'b1);
		switch_to(3'h2);
		check_sel(st.current_select, 3'h1);
		i_cfg = 10'h000;
		cyc(20);
		check_sel(st.current_select, 3'h1);
		do_reset(3'h0, 2'h3, 2'h2, 1'b0, 2'h0);
		switch_to(3'h5);
		check_sel(st.current_select, 3'h0);
		$display("test switch done");
		// Fail-safe monitor on a stopped secondary oscillator
		stop = 5'h02;
		do_reset(3'h4, 2'h0, 2'h0, 1'b0, 2'h0);
		check_bit(st.monitor_active, 1'b1);
		n = 0;
		while (st.clock_fail !== 1'b1 && n < 700) begin
			cyc(1);
			n++;
		end
		check_bit(n >= `SCS_FAIL_CYCLES - 10 && n <= `SCS_FAIL_CYCLES + 10, 1'b1);
		check_sel(st.current_select, 3'h0);
		check_bit(st.monitor_active, 1'b0);
		i_fail_clear = 1'b1;
		cyc(1);
		i_fail_clear = 1'b0;
		cyc(2);
		check_bit(st.clock_fail, 1'b0);
		do_reset(3'h4, 2'h0, 2'h1, 1'b0, 2'h0);
		cyc(600);
		check_bit(st.clock_fail, 1'b0);
		check_sel(st.current_select, 3'h4);
		stop = 5'h00;
		$display("test monitor done");
		print_verdict();
	end
endmodule : tb_scs_clock_select
`default_nettype wire

// ### rtl/scs_clock_select.sv
// Contract
// - Instruction clock is the selected system clock divided by two.
// - Primary output pin may carry the instruction clock in some primary modes.
// - Times-four multiplier only for primary oscillator and fast internal RC.
// - Fast internal RC frequency lowered by a programmable postscaler.
// - One configuration bit picks high-power or low-power secondary oscillator.
// - Power-on source chosen from two-bit primary mode and three-bit select.
// - Erased configuration starts on fast RC with postscaler, modes 11 and 111.
// - Two-bit external clock range field tunes power in external clock mode.
// - Unprogrammed range field means external frequency above 8 MHz.
// - Runtime switching allowed only when upper switch/monitor bit is low.
// - Fail-safe monitor active only when both switch/monitor bits are low.
// - Enabled monitor detects loss of running clock for recovery.
// - Select 011 is primary with multiplier, mode 10 crystal or 00 external; the code also accepts mode 01.
// - Select 010 is plain primary, modes 10, 01 or 00.
// - Select 001 with mode 11 is fast RC with multiplier.
// - Select 101 is low-power RC; select 110 is slow RC with postscaler.
// - Select 100 with mode 00 is the secondary oscillator.
// - Select 000 with mode 11 is plain fast RC.
`include "scs_consts.svh"
`default_nettype none
module scs_clock_select
	import scs_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Configuration storage
	input wire scs_cfg_t i_cfg,
	input wire logic i_out_pin_clock_en,
	// Oscillator lines
	input wire scs_osc_t i_osc,
	// Postscaler and switching control
	input wire logic [2:0] i_rc_divider,
	input wire logic i_switch_req,
	input wire logic [2:0] i_new_select,
	input wire logic i_fail_clear,
	// Clock outputs
	output logic o_system_tick,
	output logic o_instruction_clock,
	output logic o_instruction_tick,
	// Primary output pin
	output logic o_primary_out_pin,
	output logic o_primary_out_oe_n,
	// Status and hints
	output scs_status_t o_status,
	output logic o_secondary_high_power,
	output logic [1:0] o_ext_range,
	output logic o_ext_above_8mhz
);

	typedef struct packed {
		scs_state_t state;
		scs_cfg_t cfg;
		scs_choice_t cur;
		logic fail_flag;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
		logic instr;
		logic instr_tick;
		logic out_drive;
	} scs_top_state_t;

	localparam scs_cfg_t ERASED_CFG = '{
		switch_monitor_cfg: `SCS_ERASED_SWMON,
		secondary_power_select: `SCS_ERASED_SEC_POWER,
		ext_clock_range_field: `SCS_ERASED_RANGE,
		primary_mode_field: `SCS_ERASED_PMODE,
		initial_osc_select: `SCS_ERASED_SELECT
	};

	scs_top_state_t st_ff, nxt_st;
	logic post_tick;
	logic mon_fail;
	logic src_edge;
	logic switch_ok;
	logic monitor_on;
	scs_choice_t req_choice;

	// Decode select and primary mode into a source choice
	function automatic scs_choice_t scs_decode(input logic [2:0] sel, input logic [1:0] pmode);
		scs_choice_t ch;
		ch = '{valid: 1'b1, sel: sel, pll: 1'b0, postscale: 1'b0};
		case (sel)
			`SCS_SEL_FAST_RC: ch.valid = 1'b1;
			`SCS_SEL_FAST_RC_MULT: begin
				ch.pll = 1'b1;
				ch.postscale = 1'b1;
			end
			`SCS_SEL_PRIMARY: ch.valid = (pmode != `SCS_PMODE_OFF);
			`SCS_SEL_PRIMARY_MULT: begin
				ch.valid = (pmode != `SCS_PMODE_OFF);
				ch.pll = 1'b1;
			end
			`SCS_SEL_SECONDARY: ch.valid = 1'b1;
			`SCS_SEL_LOW_POWER_RC: ch.valid = 1'b1;
			`SCS_SEL_SLOW_RC_DIV: ch.postscale = 1'b1;
			`SCS_SEL_FAST_RC_DIV: ch.postscale = 1'b1;
			default: ch.valid = 1'b0;
		endcase
		return ch;
	endfunction : scs_decode

	// Map a select code onto its oscillator line
	function automatic logic [2:0] scs_line(input logic [2:0] sel);
		logic [2:0] ln;
		ln = `SCS_LINE_FAST_RC;
		case (sel)
			`SCS_SEL_PRIMARY, `SCS_SEL_PRIMARY_MULT: ln = `SCS_LINE_PRIMARY;
			`SCS_SEL_SECONDARY: ln = `SCS_LINE_SECONDARY;
			`SCS_SEL_LOW_POWER_RC: ln = `SCS_LINE_LOW_POWER_RC;
			`SCS_SEL_SLOW_RC_DIV: ln = `SCS_LINE_SLOW_RC;
			default: ln = `SCS_LINE_FAST_RC;
		endcase
		return ln;
	endfunction : scs_line

	// Rising edge of the selected, synchronised source
	assign src_edge = st_ff.sync2[scs_line(st_ff.cur.sel)] & ~st_ff.prev[scs_line(st_ff.cur.sel)];
	assign switch_ok = (st_ff.cfg.switch_monitor_cfg[1] == 1'b0);
	assign monitor_on = (st_ff.cfg.switch_monitor_cfg == 2'h0) && (st_ff.state == SCS_RUN);
	assign req_choice = scs_decode(i_new_select, st_ff.cfg.primary_mode_field);

	scs_postscaler u_postscaler (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_tick(src_edge),
		.i_enable(st_ff.cur.postscale),
		.i_divider(i_rc_divider),
		.o_tick(post_tick)
	);

	scs_fail_monitor u_fail_monitor (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_active(monitor_on),
		.i_source_edge(src_edge),
		.i_restart(i_switch_req),
		.o_fail(mon_fail)
	);

	// Control state, source choice and instruction clock
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = i_osc;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev = st_ff.sync2;
		nxt_st.instr_tick = 1'b0;
		case (st_ff.state)
			SCS_LOAD: begin
				nxt_st.cfg = i_cfg;
				nxt_st.cur = scs_decode(i_cfg.initial_osc_select, i_cfg.primary_mode_field);
				if (!nxt_st.cur.valid) begin
					nxt_st.cur = scs_decode(`SCS_SEL_FAST_RC, `SCS_PMODE_OFF);
				end
				nxt_st.state = SCS_RUN;
			end
			SCS_RUN: begin
				if (mon_fail) begin
					nxt_st.cur = scs_decode(`SCS_SEL_FAST_RC, `SCS_PMODE_OFF);
					nxt_st.state = SCS_FAILED;
				end else if (i_switch_req && switch_ok && req_choice.valid) begin
					nxt_st.cur = req_choice;
				end
			end
			SCS_FAILED: begin
				if (i_switch_req && switch_ok && req_choice.valid) begin
					nxt_st.cur = req_choice;
					nxt_st.state = SCS_RUN;
				end
			end
			default: nxt_st.state = SCS_LOAD;
		endcase
		// Sticky loss flag, new loss wins over clear
		if (mon_fail) begin
			nxt_st.fail_flag = 1'b1;
		end else if (i_fail_clear) begin
			nxt_st.fail_flag = 1'b0;
		end
		// Halve the system clock
		if (post_tick) begin
			nxt_st.instr = ~st_ff.instr;
			nxt_st.instr_tick = ~st_ff.instr;
		end
		// Drive the primary output pin in external clock mode only
		nxt_st.out_drive = i_out_pin_clock_en
			&& (st_ff.cfg.primary_mode_field == `SCS_PMODE_EXT_CLOCK)
			&& (nxt_st.cur.sel == `SCS_SEL_PRIMARY || nxt_st.cur.sel == `SCS_SEL_PRIMARY_MULT)
			&& (st_ff.state != SCS_LOAD);
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '{
				state: SCS_LOAD,
				cfg: ERASED_CFG,
				cur: '{valid: 1'b1, sel: `SCS_SEL_FAST_RC_DIV, pll: 1'b0, postscale: 1'b1},
				fail_flag: 1'b0,
				sync1: 5'h00,
				sync2: 5'h00,
				prev: 5'h00,
				instr: 1'b0,
				instr_tick: 1'b0,
				out_drive: 1'b0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign o_system_tick = post_tick;
	assign o_instruction_clock = st_ff.instr;
	assign o_instruction_tick = st_ff.instr_tick;
	assign o_primary_out_pin = st_ff.out_drive & st_ff.instr;
	assign o_primary_out_oe_n = ~st_ff.out_drive;
	assign o_secondary_high_power = st_ff.cfg.secondary_power_select;
	assign o_ext_range = st_ff.cfg.ext_clock_range_field;
	assign o_ext_above_8mhz = (st_ff.cfg.ext_clock_range_field == `SCS_RANGE_ABOVE_8MHZ);
	assign o_status = '{
		current_select: st_ff.cur.sel,
		pll_enable: st_ff.cur.pll,
		postscale_on: st_ff.cur.postscale,
		switch_allowed: switch_ok,
		monitor_active: monitor_on,
		clock_fail: st_ff.fail_flag
	};

	// Two system ticks make one instruction period
	instr_div_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		post_tick |=> (o_instruction_clock != $past(o_instruction_clock)))
		else $error("instruction clock did not toggle");

	out_pin_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		!o_primary_out_oe_n |-> (o_status.current_select[2:1] == 2'h1
			&& st_ff.cfg.primary_mode_field == `SCS_PMODE_EXT_CLOCK))
		else $error("output pin driven outside external clock primary mode");

	pll_source_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_status.pll_enable |-> (o_status.current_select == `SCS_SEL_PRIMARY_MULT
			|| o_status.current_select == `SCS_SEL_FAST_RC_MULT))
		else $error("multiplier on a source that has none");

	load_config_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_LOAD) |=> (st_ff.state == SCS_RUN && st_ff.cfg == $past(i_cfg)))
		else $error("configuration not caught at power-on");

	erased_start_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_LOAD && i_cfg == ERASED_CFG) |=>
			(o_status.current_select == `SCS_SEL_FAST_RC_DIV && o_status.postscale_on))
		else $error("erased configuration did not start on divided fast RC");

	switch_lock_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state != SCS_LOAD && !switch_ok) |=> $stable(o_status.current_select))
		else $error("source changed while switching is locked");

	monitor_gate_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		mon_fail |-> $past(st_ff.cfg.switch_monitor_cfg == 2'h0))
		else $error("clock loss reported with monitor disabled");

	fail_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		mon_fail |=> (o_status.clock_fail && o_status.current_select == `SCS_SEL_FAST_RC))
		else $error("clock loss did not fall back to fast RC");

	hold_select_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state != SCS_LOAD && !i_switch_req && !mon_fail) |=>
			$stable(o_status.current_select))
		else $error("source changed without a switch");

	range_hint_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_LOAD && i_cfg.ext_clock_range_field == `SCS_ERASED_RANGE)
			|=> o_ext_above_8mhz)
		else $error("unprogrammed range not treated as above 8 MHz");

	// Primary is chosen only with a live primary mode
	primary_mode_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state != SCS_LOAD && o_status.current_select[2:1] == 2'h1)
			|-> (st_ff.cfg.primary_mode_field != `SCS_PMODE_OFF))
		else $error("primary source chosen with primary mode off");

	// Postscaler runs only on the divided or multiplied RC codes
	postscale_src_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_status.postscale_on |-> (o_status.current_select == `SCS_SEL_FAST_RC_MULT
			|| o_status.current_select == `SCS_SEL_SLOW_RC_DIV
			|| o_status.current_select == `SCS_SEL_FAST_RC_DIV))
		else $error("postscaler on a source without one");

	// Instruction tick marks a rising instruction clock
	instr_tick_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_instruction_tick |-> (o_instruction_clock && !$past(o_instruction_clock)))
		else $error("instruction tick without a rising instruction clock");

	// Latched configuration never moves after power-on
	cfg_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state != SCS_LOAD) |=> $stable(st_ff.cfg))
		else $error("configuration changed after power-on");

	// Main scenarios
	switch_done_c: cover property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_RUN && i_switch_req && switch_ok && req_choice.valid));
	fail_recover_c: cover property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_FAILED && i_switch_req && switch_ok));
	out_pin_c: cover property (@(posedge i_clock) disable iff (!i_rstn) !o_primary_out_oe_n);
	erased_start_c: cover property (@(posedge i_clock) disable iff (!i_rstn)
		(st_ff.state == SCS_LOAD && i_cfg == ERASED_CFG));

endmodule : scs_clock_select
`default_nettype wire

// ### rtl/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Initial select encodings
`define SCS_SEL_FAST_RC 3'h0
`define SCS_SEL_FAST_RC_MULT 3'h1
`define SCS_SEL_PRIMARY 3'h2
`define SCS_SEL_PRIMARY_MULT 3'h3
`define SCS_SEL_SECONDARY 3'h4
`define SCS_SEL_LOW_POWER_RC 3'h5
`define SCS_SEL_SLOW_RC_DIV 3'h6
`define SCS_SEL_FAST_RC_DIV 3'h7

// Primary mode encodings
`define SCS_PMODE_EXT_CLOCK 2'h0
`define SCS_PMODE_STD_XTAL 2'h1
`define SCS_PMODE_HS_XTAL 2'h2
`define SCS_PMODE_OFF 2'h3

// Erased configuration values
`define SCS_ERASED_SELECT 3'h7
`define SCS_ERASED_PMODE 2'h3
`define SCS_ERASED_RANGE 2'h3
`define SCS_ERASED_SWMON 2'h3
`define SCS_ERASED_SEC_POWER 1'h1

// Range field value meaning above 8 MHz
`define SCS_RANGE_ABOVE_8MHZ 2'h3

// Source line indices
`define SCS_LINE_PRIMARY 3'h0
`define SCS_LINE_SECONDARY 3'h1
`define SCS_LINE_FAST_RC 3'h2
`define SCS_LINE_SLOW_RC 3'h3
`define SCS_LINE_LOW_POWER_RC 3'h4

// Fail-safe timeout
`define SCS_CLOCK_PERIOD_NS 4
`define SCS_FAIL_TIME_NS 2000
`define SCS_FAIL_CYCLES ((`SCS_FAIL_TIME_NS) / (`SCS_CLOCK_PERIOD_NS))

`endif

// ### rtl/scs_fail_monitor.sv
`include "scs_consts.svh"
`default_nettype none
module scs_fail_monitor
	import scs_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Watch control
	input wire logic i_active,
	input wire logic i_source_edge,
	input wire logic i_restart,
	// Loss pulse
	output logic o_fail
);

	typedef struct packed {
		logic [9:0] cnt;
		logic fail;
	} scs_mon_state_t;

	localparam logic [9:0] FAIL_LIMIT = 10'(`SCS_FAIL_CYCLES - 1);

	scs_mon_state_t st_ff, nxt_st;

	// Count cycles without a source edge
	always_comb begin
		nxt_st = st_ff;
		nxt_st.fail = 1'b0;
		if (!i_active || i_restart || i_source_edge) begin
			nxt_st.cnt = 10'h000;
		end else if (st_ff.cnt >= FAIL_LIMIT) begin
			nxt_st.cnt = 10'h000;
			nxt_st.fail = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 10'h001;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_fail = st_ff.fail;

	// Silence long enough raises the loss pulse
	loss_detect_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_active && !i_restart && !i_source_edge && st_ff.cnt == FAIL_LIMIT) |=> o_fail)
		else $error("clock loss not reported");

	fail_monitor_c: cover property (@(posedge i_clock) disable iff (!i_rstn) o_fail);

endmodule : scs_fail_monitor
`default_nettype wire

// ### rtl/scs_pkg.sv
`default_nettype none
package scs_pkg;

	// Configuration fields caught at power-on
	typedef struct packed {
		logic [1:0] switch_monitor_cfg;
		logic secondary_power_select;
		logic [1:0] ext_clock_range_field;
		logic [1:0] primary_mode_field;
		logic [2:0] initial_osc_select;
	} scs_cfg_t;

	// Oscillator lines from outside
	typedef struct packed {
		logic low_power_rc;
		logic slow_rc;
		logic fast_internal_rc;
		logic secondary_oscillator;
		logic primary_in_pin;
	} scs_osc_t;

	// Decoded source choice
	typedef struct packed {
		logic valid;
		logic [2:0] sel;
		logic pll;
		logic postscale;
	} scs_choice_t;

	// Status seen by the core
	typedef struct packed {
		logic [2:0] current_select;
		logic pll_enable;
		logic postscale_on;
		logic switch_allowed;
		logic monitor_active;
		logic clock_fail;
	} scs_status_t;

	// Gray-coded control states
	typedef enum logic [1:0] {
		SCS_LOAD = 2'h0,
		SCS_RUN = 2'h1,
		SCS_FAILED = 2'h3
	} scs_state_t;

endpackage : scs_pkg
`default_nettype wire

// ### rtl/scs_postscaler.sv
`include "scs_consts.svh"
`default_nettype none
module scs_postscaler
	import scs_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Tick in, control
	input wire logic i_tick,
	input wire logic i_enable,
	input wire logic [2:0] i_divider,
	// Divided tick
	output logic o_tick
);

	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} scs_ps_state_t;

	scs_ps_state_t st_ff, nxt_st;

	// Terminal count: divide by 1..64 as powers of two, top code by 256
	function automatic logic [7:0] scs_div_limit(input logic [2:0] div);
		logic [7:0] lim;
		lim = 8'hff;
		if (div != 3'h7) begin
			lim = 8'((9'h1 << div) - 9'h1);
		end
		return lim;
	endfunction : scs_div_limit

	// Count input ticks, emit one per full period
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (!i_enable) begin
			nxt_st.cnt = 8'h00;
			nxt_st.tick = i_tick;
		end else if (i_tick) begin
			if (st_ff.cnt >= scs_div_limit(i_divider)) begin
				nxt_st.cnt = 8'h00;
				nxt_st.tick = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_tick = st_ff.tick;

	// Divide by 2 passes every second tick
	post_div_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
		(i_enable && i_divider == 3'h1 && $stable(i_divider) && i_tick && st_ff.cnt == 8'h01)
		|=> o_tick)
		else $error("postscaler missed divided tick");

endmodule : scs_postscaler
`default_nettype wire
